// ===== design/ulm_pkg.sv
package ulm_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  // Memory bank codes on the air interface
  localparam logic [1:0] BANK_RESERVED = 2'h0;
  localparam logic [1:0] BANK_EPC = 2'h1;
  localparam logic [1:0] BANK_TID = 2'h2;
  localparam logic [1:0] BANK_USER = 2'h3;
  // Word boundaries, large map
  localparam logic [7:0] RES_LAST = 8'h03;
  localparam logic [7:0] PC_LAST = 8'h01;
  localparam logic [7:0] EPC_FIRST = 8'h02;
  localparam logic [7:0] EPC_LAST = 8'h0F;
  localparam logic [7:0] XPC_ADDR = 8'h21;
  localparam logic [7:0] TID_LAST = 8'h05;
  localparam logic [7:0] USR_LAST = 8'h03;
  localparam logic [7:0] SHR_FIRST = 8'h20;
  localparam logic [7:0] SHL_FIRST = 8'hDE;
  localparam logic [7:0] SHL_LAST = 8'hE1;
  localparam int unsigned EPC_WORDS = 14;
  localparam int unsigned SHL_WORDS = 4;
  // Sharing lock layout: one read bit and one write bit per 8-word block of the shared region
  localparam int unsigned SHL_BLK_SHIFT = 3;
  localparam logic [1:0] SHL_RD_BASE = 2'h0;
  localparam logic [1:0] SHL_WR_BASE = 2'h2;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  typedef enum logic [3:0] {
    RG_NONE = 4'b0000,
    RG_RESERVED = 4'b0001,
    RG_PC = 4'b0010,
    RG_EPC = 4'b0011,
    RG_XPC = 4'b0100,
    RG_TID = 4'b0101,
    RG_USER = 4'b0110,
    RG_SHARED = 4'b0111,
    RG_SHLOCK = 4'b1000
  } ulm_region_t;
endpackage : ulm_pkg

// ===== design/ulm_decode.sv
`timescale 1ns/1ps
module ulm_decode (
  input wire logic [1:0] bank_i,
  input wire logic [ulm_pkg::ADDR_W-1:0] addr_i,
  output ulm_pkg::ulm_region_t region_o
);
  import ulm_pkg::*;

  always_comb begin
    region_o = RG_NONE;
    case (bank_i)
      BANK_RESERVED: begin
        if (addr_i <= RES_LAST) region_o = RG_RESERVED;
      end
      BANK_EPC: begin
        if (addr_i <= PC_LAST) region_o = RG_PC;
        else if (addr_i <= EPC_LAST) region_o = RG_EPC;
        else if (addr_i == XPC_ADDR) region_o = RG_XPC;
      end
      BANK_TID: begin
        if (addr_i <= TID_LAST) region_o = RG_TID;
      end
      BANK_USER: begin
        if (addr_i <= USR_LAST) region_o = RG_USER;
        else if (addr_i >= SHL_FIRST && addr_i <= SHL_LAST) region_o = RG_SHLOCK;
        else if (addr_i >= SHR_FIRST) region_o = RG_SHARED;
      end
      default: region_o = RG_NONE;
    endcase
  end
endmodule : ulm_decode

// ===== design/ulm_access_ctrl.sv
// Operation
// - 224-bit EPC held in EPC words 2 to 15, most significant word first
// - XPC word at EPC word 33; words 16 to 32 give no access
// - USER words 32 to 255, other than lock words 222 to 225, map to shared memory; 4 to 31 unused
// - Shared access checks user password and lock before sharing lock bytes
// - Shared reads and writes allowed only where sharing lock bytes grant
// - Hidden user bank also hides the shared region
// - Sharing lock bytes held in USER words 222 to 225, read and write
`timescale 1ns/1ps
module ulm_access_ctrl (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [1:0] bank_i,
  input wire logic [ulm_pkg::ADDR_W-1:0] addr_i,
  input wire logic [ulm_pkg::DATA_W-1:0] wdata_i,
  input wire logic user_pw_deny_i,
  input wire logic user_hidden_i,
  output logic resp_valid_o,
  output logic resp_err_o,
  output logic [ulm_pkg::DATA_W-1:0] rdata_o,
  output logic ext_req_o,
  output logic ext_we_o,
  output logic ext_nfc_o,
  output logic [1:0] ext_bank_o,
  output logic [ulm_pkg::ADDR_W-1:0] ext_addr_o,
  output logic [ulm_pkg::DATA_W-1:0] ext_wdata_o
);
  import ulm_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic [EPC_WORDS-1:0][DATA_W-1:0] epc;
    logic [SHL_WORDS-1:0][DATA_W-1:0] shl;
    logic resp_valid;
    logic resp_err;
    logic [DATA_W-1:0] rdata;
    logic ext_req;
    logic ext_we;
    logic ext_nfc;
    logic [1:0] ext_bank;
    logic [ADDR_W-1:0] ext_addr;
    logic [DATA_W-1:0] ext_wdata;
  } ulm_state_t;

  ulm_state_t st_reg;
  ulm_state_t st_next;
  ulm_region_t region;

  ulm_decode u_decode (
    .bank_i(bank_i),
    .addr_i(addr_i),
    .region_o(region)
  );

  // ==========================================================
  // Sharing lock lookup
  // Lock words themselves sit in the shared range, so they can lock themselves
  function automatic logic shl_deny(input logic [SHL_WORDS-1:0][DATA_W-1:0] shl,
                                    input logic [ADDR_W-1:0] addr, input logic wr);
    logic [ADDR_W-1:0] off;
    logic [4:0] blk;
    logic [1:0] widx;
    off = addr - SHR_FIRST;
    blk = 5'(off >> SHL_BLK_SHIFT);
    widx = (wr ? SHL_WR_BASE : SHL_RD_BASE) + {1'b0, blk[4]};
    shl_deny = shl[widx][blk[3:0]];
  endfunction : shl_deny

  logic deny;
  logic [3:0] epc_idx;
  logic [1:0] shl_idx;
  logic shl_hit;

  always_comb begin
    epc_idx = 4'(addr_i - EPC_FIRST);
    shl_idx = 2'(addr_i - SHL_FIRST);
    // Kept as a net so the lock check can look back one cycle
    shl_hit = shl_deny(st_reg.shl, addr_i, we_i);
    deny = (region == RG_NONE);
    // Read-only identity bank
    if (region == RG_TID && we_i) deny = 1'b1;
    if (region == RG_USER || region == RG_SHARED || region == RG_SHLOCK) begin
      if (user_hidden_i) deny = 1'b1;
      else if (user_pw_deny_i) deny = 1'b1;
      else if (region != RG_USER && shl_hit) deny = 1'b1;
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    st_next.resp_valid = req_i;
    st_next.resp_err = 1'b0;
    st_next.ext_req = 1'b0;
    st_next.ext_we = 1'b0;
    if (req_i) begin
      st_next.rdata = RESET_WORD;
      if (deny) begin
        st_next.resp_err = 1'b1;
      end else if (region == RG_EPC) begin
        if (we_i) st_next.epc[epc_idx] = wdata_i;
        else st_next.rdata = st_reg.epc[epc_idx];
      end else if (region == RG_SHLOCK) begin
        if (we_i) st_next.shl[shl_idx] = wdata_i;
        else st_next.rdata = st_reg.shl[shl_idx];
      end else begin
        st_next.ext_req = 1'b1;
        st_next.ext_we = we_i;
        st_next.ext_nfc = (region == RG_SHARED);
        st_next.ext_bank = bank_i;
        st_next.ext_addr = (region == RG_SHARED) ? addr_i - SHR_FIRST : addr_i;
        st_next.ext_wdata = wdata_i;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign resp_valid_o = st_reg.resp_valid;
  assign resp_err_o = st_reg.resp_err;
  assign rdata_o = st_reg.rdata;
  assign ext_req_o = st_reg.ext_req;
  assign ext_we_o = st_reg.ext_we;
  assign ext_nfc_o = st_reg.ext_nfc;
  assign ext_bank_o = st_reg.ext_bank;
  assign ext_addr_o = st_reg.ext_addr;
  assign ext_wdata_o = st_reg.ext_wdata;

  // ==========================================================
  // Checks
  chk_unused_err: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    req_i && region == RG_NONE |=> resp_valid_o && resp_err_o)
    else $error("unused word not refused");

  chk_err_no_ext: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    resp_err_o |-> !ext_req_o && $stable(st_reg.epc) && $stable(st_reg.shl))
    else $error("refused access touched memory");

  chk_hidden_user: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    req_i && bank_i == BANK_USER && user_hidden_i |=> resp_err_o)
    else $error("hidden user bank accessed");

  chk_pw_first: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    req_i && region == RG_SHARED && user_pw_deny_i |=> resp_err_o && !ext_req_o)
    else $error("password check bypassed");

  chk_shared_lock: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    req_i && region == RG_SHARED && !user_hidden_i && !user_pw_deny_i
      |=> (ext_req_o && ext_nfc_o) != $past(shl_hit))
    else $error("sharing lock not applied");

  chk_shared_addr: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    ext_req_o && ext_nfc_o |-> ext_addr_o == $past(addr_i) - SHR_FIRST && ext_bank_o == BANK_USER)
    else $error("shared address mapped wrong");

  chk_epc_store: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    req_i && we_i && region == RG_EPC && !deny
      ##1 req_i && !we_i && region == RG_EPC && addr_i == $past(addr_i)
      |=> rdata_o == $past(wdata_i, 2))
    else $error("EPC word not stored");

  chk_xpc_fwd: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    req_i && bank_i == BANK_EPC && addr_i == XPC_ADDR |=> ext_req_o && ext_addr_o == XPC_ADDR)
    else $error("XPC word not forwarded");

  chk_lock_store: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    req_i && we_i && region == RG_SHLOCK && !deny |=> st_reg.shl[$past(shl_idx)] == $past(wdata_i))
    else $error("sharing lock word not written");

  chk_resp_pulse: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    resp_valid_o == $past(req_i))
    else $error("response not one cycle after request");

  chk_err_no_data: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    resp_err_o |-> resp_valid_o && rdata_o == RESET_WORD)
    else $error("refused access returned data");

  chk_ext_ok: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    ext_req_o |-> resp_valid_o && !resp_err_o)
    else $error("forwarded access without clean response");

  chk_epc_gap: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    req_i && bank_i == BANK_EPC && addr_i > EPC_LAST && addr_i < XPC_ADDR |=> resp_err_o && !ext_req_o)
    else $error("EPC gap word not refused");

  chk_user_gap: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    req_i && bank_i == BANK_USER && addr_i > USR_LAST && addr_i < SHR_FIRST |=> resp_err_o && !ext_req_o)
    else $error("user gap word not refused");

  chk_user_fwd: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    req_i && region == RG_USER && !deny |=> ext_req_o && !ext_nfc_o && ext_addr_o == $past(addr_i))
    else $error("user word not forwarded to long-range store");

  chk_shared_fwd: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    req_i && region == RG_SHARED && !deny |=> ext_req_o && ext_nfc_o && ext_we_o == $past(we_i))
    else $error("granted shared access not forwarded");

  chk_lock_pw: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    req_i && region == RG_SHLOCK && (user_pw_deny_i || user_hidden_i) |=> resp_err_o)
    else $error("lock word reached past user bank gate");

  chk_lock_self: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    req_i && region == RG_SHLOCK && shl_hit |=> resp_err_o)
    else $error("locked lock word accessed");

  chk_local_no_ext: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    req_i && (region == RG_EPC || region == RG_SHLOCK) |=> !ext_req_o)
    else $error("locally held word forwarded");
endmodule : ulm_access_ctrl

// ===== bench/ulm_far_mem.sv
`timescale 1ns/1ps
// ====
// Far side: external memory stub for every forwarded bank, only counts forwarded accesses
module ulm_far_mem (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic ext_req_i,
  output int fwd_count_o
);
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fwd_count_o <= 0;
    end else if (ext_req_i) begin
      fwd_count_o <= fwd_count_o + 1;
    end
  end
endmodule : ulm_far_mem

// ===== bench/test_uhf_large_map_access_control.sv
`timescale 1ns/1ps
module test_uhf_large_map_access_control;
  import ulm_pkg::*;
  logic mclk_i = 0, reset_n_i = 0, req_i = 0, we_i = 0, pw = 0, hid = 0;
  logic [1:0] bank_i = 0;
  logic [7:0] addr_i = 0;
  logic [15:0] wdata_i = 0;
  logic rv, re, xr, xw, xn;
  logic [1:0] xb;
  logic [7:0] xa;
  logic [15:0] rd, xd;
  int fail_count = 0, checks_done = 0, cyc = 0, exp_fwd = 0, fwd;
  ulm_access_ctrl ulm_access_ctrl_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .req_i(req_i),
    .we_i(we_i), .bank_i(bank_i), .addr_i(addr_i), .wdata_i(wdata_i), .user_pw_deny_i(pw),
    .user_hidden_i(hid), .resp_valid_o(rv), .resp_err_o(re), .rdata_o(rd), .ext_req_o(xr),
    .ext_we_o(xw), .ext_nfc_o(xn), .ext_bank_o(xb), .ext_addr_o(xa), .ext_wdata_o(xd));
  ulm_far_mem ulm_far_mem_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .ext_req_i(xr),
    .fwd_count_o(fwd));
  initial forever #2 mclk_i = ~mclk_i;
  // Hang guard, run needs well under 200 cycles
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      wrap_up();
    end
  end
  task wrap_up;
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // Request held back to back; checked at the negedge after it is taken
  task acc(input logic w, input logic [1:0] b, input logic [7:0] a, input logic [15:0] d,
           input logic err, input logic f, input logic [15:0] exp_rd);
    req_i = 1;
    we_i = w;
    bank_i = b;
    addr_i = a;
    wdata_i = d;
    @(negedge mclk_i);
    if (f) exp_fwd++;
    cmp({12'h0, rv, re, xr, xw}, {12'h0, 1'b1, err, f, f & w});
    if (!w && !f) cmp(rd, exp_rd);
  endtask : acc
  task t_epc;
    for (int i = 2; i < 16; i++) acc(1, BANK_EPC, i[7:0], 16'hA500 + 16'(i), 0, 0, 0);
    for (int i = 2; i < 16; i++) acc(0, BANK_EPC, i[7:0], 0, 0, 0, 16'hA500 + 16'(i));
    acc(1, BANK_EPC, 8'h05, 16'h5AA5, 0, 0, 0);
    acc(0, BANK_EPC, 8'h05, 0, 0, 0, 16'h5AA5);
  endtask : t_epc
  task t_map;
    acc(0, BANK_EPC, 8'h10, 0, 1, 0, 0);
    acc(1, BANK_EPC, 8'h20, 16'hFFFF, 1, 0, 0);
    acc(0, BANK_EPC, 8'h21, 0, 0, 1, 0);
    acc(0, BANK_EPC, 8'h22, 0, 1, 0, 0);
    acc(0, BANK_USER, 8'h03, 0, 0, 1, 0);
    acc(0, BANK_USER, 8'h04, 0, 1, 0, 0);
    acc(1, BANK_USER, 8'h1F, 16'h1234, 1, 0, 0);
    acc(1, BANK_TID, 8'h05, 16'h1234, 1, 0, 0);
    acc(0, BANK_USER, 8'hFF, 0, 0, 1, 0);
    cmp({7'h0, xn, xa}, {8'h01, 8'hDF});
    acc(1, BANK_RESERVED, 8'h03, 16'hC3C3, 0, 1, 0);
    cmp({5'h0, xn, xb, xa}, {5'h0, 1'b0, BANK_RESERVED, 8'h03});
    cmp(xd, 16'hC3C3);
    acc(0, BANK_RESERVED, 8'h04, 0, 1, 0, 0);
    acc(0, BANK_TID, 8'h05, 0, 0, 1, 0);
    acc(0, BANK_TID, 8'h06, 0, 1, 0, 0);
    acc(1, BANK_EPC, 8'h01, 16'h3000, 0, 1, 0);
  endtask : t_map
  task t_gate;
    pw = 1;
    acc(0, BANK_USER, 8'h28, 0, 1, 0, 0);
    acc(0, BANK_USER, 8'hDE, 0, 1, 0, 0);
    pw = 0;
    hid = 1;
    acc(1, BANK_USER, 8'h28, 16'h0F0F, 1, 0, 0);
    acc(0, BANK_USER, 8'h00, 0, 1, 0, 0);
    acc(0, BANK_USER, 8'hDE, 0, 1, 0, 0);
    hid = 0;
    acc(0, BANK_USER, 8'h28, 0, 0, 1, 0);
    cmp({7'h0, xn, xa}, {8'h01, 8'h08});
  endtask : t_gate
  task t_lock;
    acc(1, BANK_USER, 8'hDE, 16'h0002, 0, 0, 0);
    acc(0, BANK_USER, 8'hDE, 0, 0, 0, 16'h0002);
    acc(0, BANK_USER, 8'h28, 0, 1, 0, 0);
    acc(1, BANK_USER, 8'h2F, 16'h5A5A, 0, 1, 0);
    cmp(xd, 16'h5A5A);
    cmp({14'h0, xb}, {14'h0, BANK_USER});
    acc(0, BANK_USER, 8'h30, 0, 0, 1, 0);
    acc(1, BANK_USER, 8'hE0, 16'h0002, 0, 0, 0);
    acc(1, BANK_USER, 8'h28, 16'h5A5A, 1, 0, 0);
    acc(1, BANK_USER, 8'hDE, 16'h0000, 0, 0, 0);
    acc(1, BANK_USER, 8'hE0, 16'h0000, 0, 0, 0);
    acc(1, BANK_USER, 8'hE1, 16'h0080, 0, 0, 0);
    acc(1, BANK_USER, 8'hDE, 16'hFFFF, 1, 0, 0);
    acc(0, BANK_USER, 8'hDE, 0, 0, 0, 16'h0000);
    acc(1, BANK_USER, 8'hE1, 16'h0000, 0, 0, 0);
    acc(0, BANK_USER, 8'h28, 0, 0, 1, 0);
  endtask : t_lock
  // Mid-run reset must clear the EPC store and the lock words
  task t_reset;
    acc(1, BANK_USER, 8'hDE, 16'h0002, 0, 0, 0);
    acc(1, BANK_EPC, 8'h02, 16'h1111, 0, 0, 0);
    cmp(16'(fwd), 16'(exp_fwd));
    req_i = 0;
    reset_n_i = 0;
    exp_fwd = 0;
    repeat (2) @(negedge mclk_i);
    cmp({12'h0, rv, re, xr, xw}, 16'h0000);
    reset_n_i = 1;
    acc(0, BANK_USER, 8'h28, 0, 0, 1, 0);
    acc(0, BANK_EPC, 8'h02, 0, 0, 0, 16'h0000);
  endtask : t_reset
  initial begin
    repeat (8) @(posedge mclk_i);
    @(negedge mclk_i);
    reset_n_i = 1;
    t_epc();
    t_map();
    t_gate();
    t_lock();
    t_reset();
    req_i = 0;
    @(negedge mclk_i);
    cmp(16'(fwd), 16'(exp_fwd));
    wrap_up();
  end
endmodule : test_uhf_large_map_access_control
